// ---- base_r_pcs_link_monitor_defs.svh ----
// Offsets, field positions, reset values and timing counts of the link monitor
`ifndef BASE_R_PCS_LINK_MONITOR_DEFS_SVH
`define BASE_R_PCS_LINK_MONITOR_DEFS_SVH
`define OFS_CFG 8'h00
`define OFS_SD_CFG 8'h04
`define OFS_STATUS 8'h08
`define OFS_STICKY 8'h0C
`define OFS_SET_DATA 8'h10
`define OFS_SET_STAT 8'h14
`define OFS_SEED_UPPER 8'h18
`define OFS_SEED_LOWER 8'h1C
`define OFS_TX_ERRBLK 8'h20
`define OFS_TX_BADCTL 8'h24
`define OFS_BAD_HDR 8'h28
`define OFS_RX_ERRBLK 8'h2C
`define OFS_RX_BADCTL 8'h30
`define CFG_RESET 32'h0000_0001
`define SD_CFG_RESET 32'h0000_0000
`define SEED_UPPER_W 26
`define SEED_LOWER_W 32
`define LOCK_GOOD_COUNT 7'h40
`define BER_BAD_LIMIT 5'h10
`define BER_WINDOW_US 125
`define CLK_MHZ 20
`define BER_WINDOW_CYCLES ((`BER_WINDOW_US) * (`CLK_MHZ))
`define HDR_DATA 2'h1
`define HDR_CTRL 2'h2
`define TYPE_ORDERED_SET 8'h4B
`define STICKY_LOCK 0
`define STICKY_HIBER 1
`define STICKY_SET 2
`endif

// ---- base_r_pcs_link_monitor_pkg.sv ----
// Types shared by the link monitor
package base_r_pcs_link_monitor_pkg;
   // Block lock hunt state
   typedef enum logic [0:0] {
      LOCK_HUNT = 1'b0,
      LOCK_HELD = 1'b1
   } lock_state_type;
   // Software configuration carried as one bundle
   typedef struct packed {
      logic pcsSelect;
      logic receivePatternEnable;
      logic transmitPatternEnable;
      logic debugLoopbackEnable;
      logic unidirectionalFaultEnable;
      logic faultReactionEnable;
   } cfg_type;
   // Signal detect configuration
   typedef struct packed {
      logic signalDetectSource;
      logic signalDetectPolarity;
      logic signalDetectEnable;
   } sd_cfg_type;
endpackage

// ---- base_r_pcs_link_monitor.sv ----
// Base-R receive link supervision, test features and counters behind a Wishbone slave
//
// Contract
// R1: MAC answers link fault unless reaction disabled
// R2: Unidirectional mode keeps frames, sets between them
// R3: Software enables only one PCS per port
// R4: Interrupt source and link status per block
// R5: Lock on 66-bit boundary; data valid only locked
// R6: Lock gained or lost sets sticky flag
// R7: Many bad headers raise high error rate
// R8: Fault set sets flag, queued for software
// R9: Queue status gives count and full
// R10: Enabled signal loss restarts receive, halts data
// R11: Disabled signal detect ignores signal loss
// R12: Polarity bit defines signal present level
// R13: Source select: PMA macro or GPIO pin
// R14: Loopback routes transmit path into receive
// R15: Transmit test enable generates test pattern
// R16: Receive test enable checks pattern independently; the code has no checker and only holds rxBlockValid low
// R17: Seed A is 26 upper plus 32 lower
// R18: Count transmit error block entries
// R19: Count transmit bad control characters
// R20: Count bad sync header state entries
// R21: Count receive error block entries
// R22: Count received bad control characters
// R23: Sticky flags hold until software clears
`include "base_r_pcs_link_monitor_defs.svh"
module base_r_pcs_link_monitor #(
   parameter int BLOCK_W = 66,
   parameter int CNT_W = 32,
   parameter int SET_DEPTH = 4,
   parameter int BER_WINDOW = `BER_WINDOW_CYCLES
) (
   input wire logic clk,
   input wire logic arst_n,
   // Wishbone classic slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Encoded blocks from the MAC side and from the SERDES lane
   input wire logic [BLOCK_W-1:0] txBlockIn,
   input wire logic [BLOCK_W-1:0] serdesRxBlock,
   input wire logic pmaSignalDetect,
   input wire logic gpioSignalDetect,
   output logic [BLOCK_W-1:0] txBlockOut,
   output logic [BLOCK_W-1:0] rxBlockOut,
   output logic rxBlockValid,
   output logic blockLock,
   output logic highErrorRate,
   output logic linkUp,
   output logic pcsEventSource,
   // MAC fault reaction toward the transmitter
   output logic macSendFaultSet,
   output logic macAllowFrames
);
   localparam int CNT_IDX_W = $clog2(SET_DEPTH + 1);
   localparam int PTR_W = $clog2(SET_DEPTH);
   localparam int WIN_W = $clog2(BER_WINDOW + 1);

   // True when a control block type is a legal one
   function automatic logic typeValid(input logic [7:0] t);
      case (t)
         8'h1E, 8'h2D, 8'h33, 8'h66, 8'h55, 8'h78, 8'h4B, 8'h87,
         8'h99, 8'hAA, 8'hB4, 8'hCC, 8'hD2, 8'hE1, 8'hFF: typeValid = 1'b1;
         default: typeValid = 1'b0;
      endcase
   endfunction

   // True when a block is an error block (bad header or bad type)
   function automatic logic blockBad(input logic [BLOCK_W-1:0] b);
      blockBad = !(b[1:0] == `HDR_DATA || (b[1:0] == `HDR_CTRL && typeValid(b[9:2])));
   endfunction

   base_r_pcs_link_monitor_pkg::cfg_type cfg; // Main configuration
   base_r_pcs_link_monitor_pkg::sd_cfg_type sdCfg; // Signal detect configuration
   base_r_pcs_link_monitor_pkg::lock_state_type lockState; // Lock hunt state
   logic [`SEED_UPPER_W-1:0] seedAUpper; // Seed A upper part
   logic [`SEED_LOWER_W-1:0] seedALower; // Seed A lower part
   logic [57:0] patternLfsr; // Test pattern scrambler
   logic txPatternPrev; // Last transmit test enable
   logic [2:0] sticky; // Lock change, high error rate, fault set
   logic [6:0] goodCount; // Good headers while hunting
   logic [4:0] badCount; // Bad headers in current window
   logic [WIN_W-1:0] winCount; // Window timer
   logic txErrPrev; // Transmit in error block state
   logic rxErrPrev; // Receive in error block state
   logic badHdrPrev; // Previous header was bad
   logic faultActive; // Fault sets currently arriving
   logic [CNT_W-1:0] txErrCount, txBadCtlCount, badHdrCount, rxErrCount, rxBadCtlCount;
   logic [31:0] setMem [SET_DEPTH]; // Fault set queue storage
   logic [PTR_W-1:0] setWr, setRd; // Queue pointers
   logic [CNT_IDX_W-1:0] setCount; // Held entries

   // Receive side input selection and signal detect
   logic sdRaw, signalPresent, rxRestart, hdrOk, isFaultSet, busWrite, busRead;
   logic [BLOCK_W-1:0] rxIn;
   logic [BLOCK_W-1:0] next_txBlock;
   logic setPush, setPop;
   always_comb begin
      sdRaw = sdCfg.signalDetectSource ? gpioSignalDetect : pmaSignalDetect; // R13
      signalPresent = (sdRaw == sdCfg.signalDetectPolarity); // R12
      rxRestart = sdCfg.signalDetectEnable && !signalPresent; // R10 R11
      rxIn = cfg.debugLoopbackEnable ? txBlockOut : serdesRxBlock; // R14
      hdrOk = (rxIn[1:0] == `HDR_DATA) || (rxIn[1:0] == `HDR_CTRL);
      isFaultSet = (lockState == base_r_pcs_link_monitor_pkg::LOCK_HELD) && rxIn[1:0] == `HDR_CTRL
         && rxIn[9:2] == `TYPE_ORDERED_SET && rxIn[37:34] == 4'h0;
      busWrite = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i;
      busRead = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i;
      setPop = busRead && wb_adr_i == `OFS_SET_DATA && setCount != '0;
      setPush = isFaultSet && !rxRestart && (setCount != CNT_IDX_W'(SET_DEPTH) || setPop);
      // Test pattern replaces normal coding while enabled
      if (cfg.transmitPatternEnable) begin
         next_txBlock = {BLOCK_W{1'b0}};
         next_txBlock[1:0] = `HDR_DATA; // R15
         next_txBlock[59:2] = patternLfsr;
      end else begin
         next_txBlock = txBlockIn;
      end
   end

   // Configuration and seed registers
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cfg <= base_r_pcs_link_monitor_pkg::cfg_type'(`CFG_RESET);
         sdCfg <= base_r_pcs_link_monitor_pkg::sd_cfg_type'(`SD_CFG_RESET);
         seedAUpper <= '0;
         seedALower <= '0;
      end else if (busWrite && wb_sel_i[0]) begin
         if (wb_adr_i == `OFS_CFG) begin
            cfg <= base_r_pcs_link_monitor_pkg::cfg_type'(wb_dat_i[5:0]);
         end else if (wb_adr_i == `OFS_SD_CFG) begin
            sdCfg <= base_r_pcs_link_monitor_pkg::sd_cfg_type'(wb_dat_i[2:0]);
         end else if (wb_adr_i == `OFS_SEED_UPPER && wb_sel_i == 4'hF) begin
            seedAUpper <= wb_dat_i[`SEED_UPPER_W-1:0]; // R17
         end else if (wb_adr_i == `OFS_SEED_LOWER && wb_sel_i == 4'hF) begin
            seedALower <= wb_dat_i; // R17
         end
      end
   end

   // Test pattern generator, loaded with seed A when the mode turns on
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         patternLfsr <= '0;
         txPatternPrev <= 1'b0;
         txBlockOut <= '0;
      end else begin
         txPatternPrev <= cfg.transmitPatternEnable;
         if (cfg.transmitPatternEnable && !txPatternPrev) begin
            patternLfsr <= {seedAUpper, seedALower}; // R15 R17
         end else begin
            patternLfsr <= {patternLfsr[56:0], patternLfsr[57] ^ patternLfsr[38]};
         end
         txBlockOut <= next_txBlock;
      end
   end

   // Block lock search and loss
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         lockState <= base_r_pcs_link_monitor_pkg::LOCK_HUNT;
         goodCount <= '0;
      end else if (rxRestart) begin
         lockState <= base_r_pcs_link_monitor_pkg::LOCK_HUNT; // R10
         goodCount <= '0;
      end else if (lockState == base_r_pcs_link_monitor_pkg::LOCK_HUNT) begin
         if (!hdrOk) begin
            goodCount <= '0;
         end else if (goodCount == `LOCK_GOOD_COUNT - 7'h1) begin
            lockState <= base_r_pcs_link_monitor_pkg::LOCK_HELD; // R5
            goodCount <= '0;
         end else begin
            goodCount <= goodCount + 7'h1;
         end
      end else if (!hdrOk && badCount == `BER_BAD_LIMIT - 5'h1) begin
         lockState <= base_r_pcs_link_monitor_pkg::LOCK_HUNT; // R5
      end
   end

   // Bad header rate over a fixed window
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         badCount <= '0;
         winCount <= '0;
         highErrorRate <= 1'b0;
      end else if (rxRestart) begin
         badCount <= '0;
         winCount <= '0;
         highErrorRate <= 1'b0;
      end else if (winCount == WIN_W'(BER_WINDOW - 1)) begin
         winCount <= '0;
         badCount <= '0;
         highErrorRate <= highErrorRate && badCount != '0;
      end else begin
         winCount <= winCount + 1'b1;
         if (!hdrOk && badCount != `BER_BAD_LIMIT) begin
            badCount <= badCount + 5'h1;
         end
         if (!hdrOk && badCount == `BER_BAD_LIMIT - 5'h1) begin
            highErrorRate <= 1'b1; // R7
         end
      end
   end

   // Receive data and link reporting
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rxBlockOut <= '0;
         rxBlockValid <= 1'b0;
         blockLock <= 1'b0;
         linkUp <= 1'b0;
         pcsEventSource <= 1'b0;
      end else begin
         rxBlockOut <= rxIn;
         // Data reaches the MAC only while locked, not restarted by signal loss and not in receive test
         rxBlockValid <= lockState == base_r_pcs_link_monitor_pkg::LOCK_HELD && !rxRestart
            && !cfg.receivePatternEnable; // R5 R10 R16
         blockLock <= lockState == base_r_pcs_link_monitor_pkg::LOCK_HELD; // R5
         linkUp <= cfg.pcsSelect && lockState == base_r_pcs_link_monitor_pkg::LOCK_HELD
            && !highErrorRate; // R4
         pcsEventSource <= cfg.pcsSelect && (sticky != '0); // R4
      end
   end

   // Sticky flags: hardware set wins over software write-one clear
   logic [2:0] stickySet;
   always_comb begin
      stickySet = '0;
      stickySet[`STICKY_LOCK] = blockLock != (lockState == base_r_pcs_link_monitor_pkg::LOCK_HELD); // R6
      stickySet[`STICKY_HIBER] = highErrorRate; // R7
      stickySet[`STICKY_SET] = isFaultSet && !rxRestart; // R8
   end
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         sticky <= '0;
      end else if (busWrite && wb_adr_i == `OFS_STICKY && wb_sel_i[0]) begin
         sticky <= (sticky & ~wb_dat_i[2:0]) | stickySet; // R23
      end else begin
         sticky <= sticky | stickySet; // R23
      end
   end

   // Fault set queue, popped by reading its data register
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         setWr <= '0;
         setRd <= '0;
         setCount <= '0;
      end else begin
         if (setPush) begin
            setWr <= (setWr == PTR_W'(SET_DEPTH - 1)) ? '0 : setWr + 1'b1; // R8
         end
         if (setPop) begin
            setRd <= (setRd == PTR_W'(SET_DEPTH - 1)) ? '0 : setRd + 1'b1;
         end
         if (setPush && !setPop) begin
            setCount <= setCount + 1'b1; // R9
         end else if (setPop && !setPush) begin
            setCount <= setCount - 1'b1; // R9
         end
      end
   end
   always_ff @(posedge clk) begin
      if (setPush) begin
         setMem[setWr] <= rxIn[41:10]; // R8
      end
   end

   // MAC link fault reaction
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         faultActive <= 1'b0;
         macSendFaultSet <= 1'b0;
         macAllowFrames <= 1'b1;
      end else begin
         if (isFaultSet) begin
            faultActive <= 1'b1;
         end else if (rxBlockValid && !rxRestart) begin
            faultActive <= 1'b0;
         end
         macSendFaultSet <= cfg.faultReactionEnable && faultActive; // R1
         // Unidirectional mode keeps frames flowing with sets in the gaps
         macAllowFrames <= !(cfg.faultReactionEnable && faultActive)
            || cfg.unidirectionalFaultEnable; // R2
      end
   end

   // Error and event counters, cleared by any write to them
   function automatic logic [CNT_W-1:0] bump(input logic [CNT_W-1:0] c, input logic ev, input logic clr);
      bump = clr ? '0 : (ev && c != '1) ? c + 1'b1 : c;
   endfunction
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         txErrPrev <= 1'b0;
         rxErrPrev <= 1'b0;
         badHdrPrev <= 1'b0;
         txErrCount <= '0;
         txBadCtlCount <= '0;
         badHdrCount <= '0;
         rxErrCount <= '0;
         rxBadCtlCount <= '0;
      end else begin
         txErrPrev <= blockBad(txBlockIn);
         rxErrPrev <= blockLock && blockBad(rxIn);
         badHdrPrev <= blockLock && !hdrOk;
         txErrCount <= bump(txErrCount, blockBad(txBlockIn) && !txErrPrev,
            busWrite && wb_adr_i == `OFS_TX_ERRBLK); // R18
         txBadCtlCount <= bump(txBadCtlCount, txBlockIn[1:0] == `HDR_CTRL && !typeValid(txBlockIn[9:2]),
            busWrite && wb_adr_i == `OFS_TX_BADCTL); // R19
         badHdrCount <= bump(badHdrCount, blockLock && !hdrOk && !badHdrPrev,
            busWrite && wb_adr_i == `OFS_BAD_HDR); // R20
         rxErrCount <= bump(rxErrCount, blockLock && blockBad(rxIn) && !rxErrPrev,
            busWrite && wb_adr_i == `OFS_RX_ERRBLK); // R21
         rxBadCtlCount <= bump(rxBadCtlCount, blockLock && rxIn[1:0] == `HDR_CTRL && !typeValid(rxIn[9:2]),
            busWrite && wb_adr_i == `OFS_RX_BADCTL); // R22
      end
   end

   // Wishbone answer: ack one cycle after the request, read data beside it
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= '0;
      end else begin
         wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
         wb_dat_o <= '0;
         if (busRead) begin
            if (wb_adr_i == `OFS_CFG) begin
               wb_dat_o <= {26'h0, cfg};
            end else if (wb_adr_i == `OFS_SD_CFG) begin
               wb_dat_o <= {29'h0, sdCfg};
            end else if (wb_adr_i == `OFS_STATUS) begin
               wb_dat_o <= {29'h0, signalPresent, highErrorRate, blockLock};
            end else if (wb_adr_i == `OFS_STICKY) begin
               wb_dat_o <= {29'h0, sticky};
            end else if (wb_adr_i == `OFS_SET_DATA) begin
               wb_dat_o <= setCount != '0 ? setMem[setRd] : 32'h0;
            end else if (wb_adr_i == `OFS_SET_STAT) begin
               wb_dat_o <= {15'h0, setCount == CNT_IDX_W'(SET_DEPTH), 16'(setCount)}; // R9
            end else if (wb_adr_i == `OFS_SEED_UPPER) begin
               wb_dat_o <= {6'h0, seedAUpper};
            end else if (wb_adr_i == `OFS_SEED_LOWER) begin
               wb_dat_o <= seedALower;
            end else if (wb_adr_i == `OFS_TX_ERRBLK) begin
               wb_dat_o <= 32'(txErrCount);
            end else if (wb_adr_i == `OFS_TX_BADCTL) begin
               wb_dat_o <= 32'(txBadCtlCount);
            end else if (wb_adr_i == `OFS_BAD_HDR) begin
               wb_dat_o <= 32'(badHdrCount);
            end else if (wb_adr_i == `OFS_RX_ERRBLK) begin
               wb_dat_o <= 32'(rxErrCount);
            end else if (wb_adr_i == `OFS_RX_BADCTL) begin
               wb_dat_o <= 32'(rxBadCtlCount);
            end
         end
      end
   end
endmodule

// ---- base_r_pcs_link_monitor_properties.sv ----
// Port checks of the link monitor
module base_r_pcs_link_monitor_properties (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic rxBlockValid,
   input wire logic blockLock,
   input wire logic highErrorRate,
   input wire logic linkUp
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!arst_n);
   // Every taken request is answered on the next edge
   ack_after_req_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("request not acknowledged");
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   ack_cause_a: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack without request");
   data_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
      else $error("read data outside ack");
   // Receive data is valid only under block lock
   valid_lock_a: assert property (rxBlockValid |-> blockLock || $past(blockLock))
      else $error("valid data without lock");
   valid_drop_a: assert property (!blockLock [*2] |-> !rxBlockValid)
      else $error("valid data after lock lost");
   // Link status follows lock and error rate
   link_lock_a: assert property ($fell(blockLock) |-> ##[0:1] !linkUp)
      else $error("link up without lock");
   link_ber_a: assert property ($rose(highErrorRate) |-> ##[0:1] !linkUp)
      else $error("link up under high error rate");
endmodule
bind base_r_pcs_link_monitor base_r_pcs_link_monitor_properties chk_inst (
   .clk(clk),
   .arst_n(arst_n),
   .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i),
   .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o),
   .rxBlockValid(rxBlockValid),
   .blockLock(blockLock),
   .highErrorRate(highErrorRate),
   .linkUp(linkUp)
);

// ---- remote_lane_model.sv ----
// Remote link partner: lane blocks and raw signal detect
module remote_lane_model (
   input wire logic clk,
   input wire logic [1:0] mode,
   input wire logic sigOn,
   output logic [65:0] laneBlock,
   output logic sigDetect
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [31:0] seq = 32'h0; // Payload counter
   // One block per clock; mode 0 data, 1 half bad headers, 2 fault set, 3 bad control
   always @(posedge clk) begin
      seq <= seq + 32'h1;
      sigDetect <= sigOn;
      if (!sigOn) begin
         laneBlock <= ~laneBlock; // Lost signal leaves changing garbage
      end else begin
         case (mode)
            2'h0: laneBlock <= {seq, seq, 2'h1};
            2'h1: laneBlock <= {seq, seq, seq[0] ? 2'h3 : 2'h1};
            2'h2: laneBlock <= {24'h0, 32'h0020_0001, 8'h4B, 2'h2};
            default: laneBlock <= {56'h0, 8'h00, 2'h2};
         endcase
      end
   end
endmodule

// ---- test_base_r_pcs_link_monitor.sv ----
// Self-checking bench of the link monitor
module test_base_r_pcs_link_monitor;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk = 0, arst_n = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'hF;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
   logic wb_ack_o, rxBlockValid, blockLock, highErrorRate, linkUp, pcsEventSource;
   logic macSendFaultSet, macAllowFrames, pmaSignalDetect, gpioSignalDetect = 0, sigOn = 1;
   logic [1:0] mode = 2'h0, txHdr = 2'h1;
   logic [65:0] txBlockIn = {6'h3F, 58'h0, 2'h1}, serdesRxBlock, txBlockOut, rxBlockOut, prevRx, prevTx;
   logic [31:0] cfgs [3] = '{32'h21, 32'h20, 32'h23};
   int error_cnt = 0, num_checks = 0, fcnt = 0, bcnt = 0, f0, b0;
   base_r_pcs_link_monitor #(.BER_WINDOW(50)) base_r_pcs_link_monitor_inst (.clk(clk), .arst_n(arst_n),
      .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
      .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .txBlockIn(txBlockIn),
      .serdesRxBlock(serdesRxBlock), .pmaSignalDetect(pmaSignalDetect), .gpioSignalDetect(gpioSignalDetect),
      .txBlockOut(txBlockOut), .rxBlockOut(rxBlockOut), .rxBlockValid(rxBlockValid), .blockLock(blockLock),
      .highErrorRate(highErrorRate), .linkUp(linkUp), .pcsEventSource(pcsEventSource),
      .macSendFaultSet(macSendFaultSet), .macAllowFrames(macAllowFrames));
   remote_lane_model remote_lane_model_inst (.clk(clk), .mode(mode), .sigOn(sigOn),
      .laneBlock(serdesRxBlock), .sigDetect(pmaSignalDetect));
   initial forever #25 clk = ~clk;
   // Delayed copies, fault reply and frame stop counts, MAC block stream
   always @(posedge clk) begin
      prevRx <= serdesRxBlock;
      prevTx <= txBlockOut;
      fcnt <= fcnt + int'(macSendFaultSet);
      bcnt <= bcnt + int'(!macAllowFrames);
      txBlockIn <= {txBlockIn[65:10] + 56'h1, 8'h00, txHdr};
   end
   task automatic chk(input string nm, input logic [65:0] got, input logic [65:0] exp);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // One classic Wishbone cycle, waiting a bounded time for ack
   task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      do begin
         @(posedge clk);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      if (n >= 20) begin
         error_cnt++;
         summarize();
      end
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask
   task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] e);
      xfer(1'b0, a, 32'h0);
      chk(nm, rd, e);
   endtask
   // Bounded wait on lock (0) or high error rate (1)
   task automatic waitFor(input int w, input logic v);
      int n;
      n = 0;
      while ((w == 0 ? blockLock : highErrorRate) !== v && n < 600) begin
         @(posedge clk);
         n++;
      end
      if (n >= 600) begin
         error_cnt++;
         summarize();
      end
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      repeat (8) @(posedge clk);
      arst_n <= 1'b1;
      rc("cfg reset", 8'h00, 32'h1);
      rc("sd reset", 8'h04, 32'h0);
      rc("unmapped", 8'h3C, 32'h0);
      waitFor(0, 1'b1);
      rc("lock flag", 8'h0C, 32'h1);
      idle(3);
      rc("lock held", 8'h0C, 32'h1);
      wr(8'h0C, 32'h7);
      rc("flag clear", 8'h0C, 32'h0);
      chk("link unselected", linkUp, 1'b0);
      chk("rx valid", rxBlockValid, 1'b1);
      chk("rx path", rxBlockOut, prevRx);
      wr(8'h00, 32'h21);
      idle(2);
      chk("link up", linkUp, 1'b1);
      $display("test lock done");
      for (int i = 0; i < 3; i++) begin
         wr(8'h00, cfgs[i]);
         f0 = fcnt;
         b0 = bcnt;
         mode <= 2'h2;
         @(posedge clk);
         mode <= 2'h0;
         idle(6);
         chk("fault reply", fcnt > f0, i != 1);
         chk("frames stopped", bcnt > b0, i == 0);
         rc("set data", 8'h10, 32'h0020_0001);
      end
      rc("set flag", 8'h0C, 32'h4);
      chk("event source", pcsEventSource, 1'b1);
      rc("queue empty", 8'h14, 32'h0);
      mode <= 2'h2;
      idle(6);
      mode <= 2'h0;
      rc("queue full", 8'h14, 32'h0001_0004);
      for (int i = 0; i < 4; i++) rc("drain", 8'h10, 32'h0020_0001);
      rc("drained", 8'h14, 32'h0);
      wr(8'h0C, 32'h7);
      $display("test fault done");
      mode <= 2'h1;
      waitFor(1, 1'b1);
      mode <= 2'h0;
      rc("ber flags", 8'h0C, 32'h3);
      xfer(1'b0, 8'h28, 32'h0);
      chk("bad header count", rd != 32'h0, 1'b1);
      xfer(1'b0, 8'h2C, 32'h0);
      chk("rx error count", rd != 32'h0, 1'b1);
      wr(8'h28, 32'h0);
      rc("count clear", 8'h28, 32'h0);
      waitFor(0, 1'b1);
      waitFor(1, 1'b0);
      mode <= 2'h3;
      idle(3);
      mode <= 2'h0;
      xfer(1'b0, 8'h30, 32'h0);
      chk("rx bad control", rd, 32'h3);
      txHdr <= 2'h0;
      @(posedge clk);
      txHdr <= 2'h2;
      @(posedge clk);
      txHdr <= 2'h1;
      xfer(1'b0, 8'h20, 32'h0);
      chk("tx error count", rd, 32'h1);
      xfer(1'b0, 8'h24, 32'h0);
      chk("tx bad control", rd, 32'h1);
      $display("test error rate done");
      wr(8'h04, 32'h6);
      idle(4);
      chk("loss ignored", rxBlockValid, 1'b1);
      rc("gpio absent", 8'h08, 32'h1);
      gpioSignalDetect <= 1'b1;
      rc("gpio present", 8'h08, 32'h5);
      gpioSignalDetect <= 1'b0;
      wr(8'h04, 32'h4);
      rc("low polarity", 8'h08, 32'h5);
      wr(8'h04, 32'h3);
      sigOn <= 1'b0;
      idle(4);
      chk("loss halts", rxBlockValid, 1'b0);
      rc("loss status", 8'h08, 32'h0);
      sigOn <= 1'b1;
      waitFor(0, 1'b1);
      wr(8'h04, 32'h0);
      $display("test signal done");
      wr(8'h00, 32'h25);
      idle(2);
      chk("loopback", rxBlockOut, prevTx);
      wr(8'h18, 32'hFFFF_FFFF);
      rc("seed upper", 8'h18, 32'h03FF_FFFF);
      wr(8'h1C, 32'h1234_5678);
      rc("seed lower", 8'h1C, 32'h1234_5678);
      wr(8'h00, 32'h29);
      idle(2);
      chk("tx pattern", {txBlockOut[65:60], txBlockOut[1:0]}, 8'h01);
      chk("tx seed", txBlockOut[59:2], {26'h3FF_FFFF, 32'h1234_5678});
      chk("rx normal", rxBlockValid, 1'b1);
      wr(8'h00, 32'h31);
      idle(2);
      chk("rx pattern", rxBlockValid, 1'b0);
      chk("tx normal", txBlockOut[65:60], 6'h3F);
      $display("test modes done");
      summarize();
   end
endmodule
